// ### bench/eectb_properties.sv
`timescale 1ns/1ns
`default_nettype none
module eectb_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Array side
  input wire logic stop_mode,
  input wire logic program_voltage_on,
  input wire logic array_access_ok,
  input wire logic array_commit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_stop_hv_off: assert property (stop_mode [*2] |-> !program_voltage_on)
    else $error("high voltage on in stop");
  a_hv_no_access: assert property (program_voltage_on |-> !array_access_ok)
    else $error("array access allowed during sequence");
  a_commit_after_hv: assert property (array_commit |-> $past(program_voltage_on) ##1 !array_commit)
    else $error("commit without high voltage or too long");
endmodule // eectb_properties
////////////////////////////////////////////////////////////////////////////////
bind eectb_top eectb_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .stop_mode(stop_mode), .program_voltage_on(program_voltage_on),
  .array_access_ok(array_access_ok), .array_commit(array_commit));
`default_nettype wire

// ### bench/eeprom_config_timebase_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "eectb_defines.vh"
module eeprom_config_timebase_ctrl_tb_top;
  localparam int DIV = 4;
  localparam int SEQ = 4;
  logic aclk = 0, aresetn = 0, por_n = 0, stop_mode = 0;
  logic [3:0] osc_div = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pv_on, acc_ok, commit;
  logic [1:0] bresp, rresp, amode;
  logic [8:0] aaddr;
  logic [7:0] adata;
  logic [65:0] q;
  logic [18:0] exp_c[$];
  logic [65:0] exp_r[$];
  logic [1:0] exp_b[$];
  int errors = 0, check_count = 0, pv_cyc = 0, i;
  always #10 aclk = ~aclk;
  // Slow reference, unrelated to bus traffic
  always @(posedge aclk) osc_div <= osc_div + 4'h1;
  always @(posedge aclk) if (pv_on) pv_cyc++;
  eectb_top #(.SEQ_TICKS(16'h0004), .FALL_TICKS(16'h0008)) u_dut (.aclk(aclk),
    .aresetn(aresetn), .por_n(por_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_mode(stop_mode), .oscillator_output_clock(osc_div[1]),
    .program_voltage_on(pv_on), .array_access_ok(acc_ok), .array_commit(commit),
    .array_addr(aaddr), .array_data(adata), .array_mode(amode));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Answers are judged here, in order, against the notes left by the drivers
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      q = exp_r.pop_front();
      chk("rdata", q[33:2] & q[65:34], rdata & q[65:34]);
      chk("rresp", {30'h0, q[1:0]}, {30'h0, rresp});
    end
    if (bvalid && bready) chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, bresp});
    if (commit && exp_c.size() == 0) chk("stray commit", 0, 1);
    else if (commit) chk("commit", {13'h0, exp_c.pop_front()},
      {13'h0, aaddr, adata, amode});
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    exp_b.push_back(r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
    input logic [1:0] r = 2'h0);
    @(posedge aclk);
    exp_r.push_back({m, e, r});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    got = rdata;
    rready <= 1'b0;
  endtask
  // Latch a target, then raise program enable with auto clear
  task start(input logic [7:0] tgt, input logic [31:0] d, input logic [7:0] ctl);
    wr(`EECTB_OFS_CTRL, {24'h0, ctl | 8'h02});
    wr(tgt, d);
    pv_cyc = 0;
    wr(`EECTB_OFS_CTRL, {24'h0, ctl | 8'h07});
  endtask
  task finish(input int lo, input int hi);
    got = 0;
    for (i = 0; i < 300 && !(got[3] && !got[0]); i++) rd(`EECTB_OFS_STAT, 0, 0);
    chk("seq end", 32'h8, got & 32'h9);
    chk("hv cycles", 1, {31'h0, pv_cyc >= lo && pv_cyc <= hi});
    wr(`EECTB_OFS_CTRL, 0);
  endtask
  task sys_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task close_out;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run is under a thousand cycles; generous margin
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    close_out;
  end
  initial begin
    void'($urandom(32'h6308));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1; por_n <= 1'b1;
    rd(`EECTB_OFS_ACFG, 32'h10, 32'h1f);
    rd(`EECTB_OFS_NCFG, 32'hf0);
    rd(`EECTB_OFS_DIVH, 32'h80, 32'h87);
    rd(`EECTB_OFS_DIVL, 32'hac);
    rd(8'h24, 0, 32'hffffffff, `EECTB_RESP_SLVERR);
    wr(8'h24, 0, `EECTB_RESP_SLVERR);
    v = $urandom;
    wr(`EECTB_OFS_DIVL, {24'h0, v[7:0]});
    wr(`EECTB_OFS_DIVH, {24'h0, 5'h10, v[10:8]});
    rd(`EECTB_OFS_DIVL, {24'h0, v[7:0]});
    rd(`EECTB_OFS_DIVH, {24'h0, 5'h10, v[10:8]}, 32'h87);
    wr(`EECTB_OFS_CTRL, 32'h02);
    wr(`EECTB_OFS_DIVL, {24'h0, ~v[7:0]});
    rd(`EECTB_OFS_DIVL, {24'h0, v[7:0]});
    wr(`EECTB_OFS_CTRL, 32'h23);
    rd(`EECTB_OFS_CTRL, 32'h22, 32'h23);
    wr(`EECTB_OFS_CTRL, 0);
    wr(`EECTB_OFS_DIVH, 32'h80);
    // Short divisor instead of the 35 us value keeps the run brief
    wr(`EECTB_OFS_DIVL, DIV);
    // Byte program on the bus clock
    exp_c.push_back({9'h085, 8'h5a, 2'b00});
    start(`EECTB_OFS_ARRW, 32'h005a0085, 8'h20);
    finish((SEQ - 1) * DIV + 1, SEQ * DIV + 1);
    chk("commit count", 0, exp_c.size());
    // Stop in mid-run suspends, then restarts
    exp_c.push_back({9'h011, 8'h3c, 2'b11});
    start(`EECTB_OFS_ARRW, 32'h003c0011, 8'h38);
    repeat (5) @(posedge aclk);
    stop_mode <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("hv in stop", 0, {31'h0, pv_on});
    chk("access in stop", 0, {31'h0, acc_ok});
    stop_mode <= 1'b0;
    finish(SEQ * DIV, 1000);
    chk("commit count", 0, exp_c.size());
    // Clear both bits at once, then stop while voltage falls
    start(`EECTB_OFS_ARRW, 32'h00010020, 8'h20);
    wr(`EECTB_OFS_CTRL, 32'h20);
    rd(`EECTB_OFS_CTRL, 32'h02, 32'h03);
    stop_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    stop_mode <= 1'b0;
    rd(`EECTB_OFS_STAT, 32'h04, 32'h04);
    wr(`EECTB_OFS_STAT, 32'h04);
    wr(`EECTB_OFS_CTRL, 0);
    // Erase config shadow on the slow reference: every block protected
    start(`EECTB_OFS_NCFG, 0, 8'h08);
    finish((SEQ - 1) * DIV * 4, SEQ * DIV * 4 + 8);
    rd(`EECTB_OFS_NCFG, 32'hff);
    sys_reset;
    rd(`EECTB_OFS_ACFG, 32'h1f, 32'h1f);
    wr(`EECTB_OFS_DIVL, DIV);
    start(`EECTB_OFS_ARRW, 32'h00550085, 8'h20);
    rd(`EECTB_OFS_CTRL, 32'h02, 32'h03);
    wr(`EECTB_OFS_CTRL, 0);
    // Program divisor shadow security to zero
    start(`EECTB_OFS_NDVH, 0, 8'h20);
    finish((SEQ - 1) * DIV + 1, SEQ * DIV + 1);
    rd(`EECTB_OFS_NDVH, 0);
    sys_reset;
    rd(`EECTB_OFS_DIVH, 0, 32'h80);
    wr(`EECTB_OFS_DIVL, 32'h33);
    rd(`EECTB_OFS_DIVL, 32'hac);
    start(`EECTB_OFS_NDVL, 0, 8'h20);
    rd(`EECTB_OFS_STAT, 0, 32'h10);
    wr(`EECTB_OFS_CTRL, 0);
    close_out;
  end
endmodule // eeprom_config_timebase_ctrl_tb_top
`default_nettype wire

// ### rtl/eectb_defines.vh
// How it works
// - Reset copies config shadow into live config
// - Config shadow uses latch-and-program sequence
// - Config shadow ships as f0, unprotected
// - Eleven-bit divisor sets 35 us timebase
// - Reset loads divisor from divisor shadows
// - Security zero locks divisor and its shadows
// - Divisor writable only unlatched and unsecured
// - Divider counts oscillator clock or bus clock
// - Divisor shadows use latch-and-program sequence
// - Shadow security zero reloads zero every reset
// - Wait mode leaves sequence running
// - Stop while programming suspends, restarts, refuses access
// - Stop after program-enable cleared aborts sequence
// - Latch cannot clear while program-enable set
// - Block protect bit blocks its 128-byte block
// - Program-enable needs latch and valid latched write
`ifndef EECTB_DEFINES_VH
`define EECTB_DEFINES_VH
// Register byte offsets
`define EECTB_OFS_CTRL 8'h00
`define EECTB_OFS_ACFG 8'h04
`define EECTB_OFS_DIVH 8'h08
`define EECTB_OFS_DIVL 8'h0c
`define EECTB_OFS_NCFG 8'h10
`define EECTB_OFS_NDVH 8'h14
`define EECTB_OFS_NDVL 8'h18
`define EECTB_OFS_STAT 8'h1c
`define EECTB_OFS_ARRW 8'h20
// Control fields
`define EECTB_CTL_PGM 0
`define EECTB_CTL_LAT 1
`define EECTB_CTL_AUTO 2
`define EECTB_CTL_MODE_LO 3
`define EECTB_CTL_MODE_HI 4
`define EECTB_CTL_REFSEL 5
// Divisor high fields
`define EECTB_DIVH_SECD 7
`define EECTB_DIVH_MASK 8'h87
// Array write field positions
`define EECTB_ARR_DATA_LO 16
`define EECTB_ARR_ADDR_HI 8
// Factory values
`define EECTB_NCFG_FACTORY 8'hf0
`define EECTB_NDVH_FACTORY 8'h80
`define EECTB_NDVL_FACTORY 8'hac
// Timing, in timebase ticks of 35 us
`define EECTB_TICK_US 35
`define EECTB_SEQ_TICKS 16'h0010
`define EECTB_FALL_TICKS 16'h0002
// Bus answers
`define EECTB_RESP_OKAY 2'b00
`define EECTB_RESP_SLVERR 2'b10
`endif

// ### rtl/eectb_divider.v
`timescale 1ns/1ns
`default_nettype none
`include "eectb_defines.vh"
module eectb_divider #(
  parameter DW = 11
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Reference selection
  input wire ref_sel,
  input wire osc_edge,
  input wire [DW-1:0] divisor,
  // Timebase
  output reg tick
);
  reg [DW-1:0] cnt_reg;
  wire ref_en;

  // Bus clock counts every cycle, oscillator only on its rising edges
  assign ref_en = ref_sel ? 1'b1 : osc_edge;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {DW{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      // Divisor of zero gives no timebase at all
      if (ref_en && (divisor != {DW{1'b0}})) begin
        if (cnt_reg >= divisor - {{(DW-1){1'b0}}, 1'b1}) begin
          cnt_reg <= {DW{1'b0}};
          tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // eectb_divider
`default_nettype wire

// ### rtl/eectb_top.v
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "eectb_defines.vh"
module eectb_top #(
  parameter [15:0] SEQ_TICKS = `EECTB_SEQ_TICKS,
  parameter [15:0] FALL_TICKS = `EECTB_FALL_TICKS
) (
  // Clock and resets
  input wire aclk,
  input wire aresetn,
  input wire por_n,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // System
  input wire stop_mode,
  input wire oscillator_output_clock,
  // Array side
  output wire program_voltage_on,
  output wire array_access_ok,
  output reg array_commit,
  output reg [8:0] array_addr,
  output reg [7:0] array_data,
  output reg [1:0] array_mode
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN = 4'b0010;
  localparam [3:0] ST_SUSP = 4'b0100;
  localparam [3:0] ST_FALL = 4'b1000;
  localparam [1:0] TGT_CFG = 2'd0;
  localparam [1:0] TGT_DVH = 2'd1;
  localparam [1:0] TGT_DVL = 2'd2;
  localparam [1:0] TGT_ARR = 2'd3;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  reg [7:0] cfg_shadow_reg;
  reg [7:0] dvh_shadow_reg;
  reg [7:0] dvl_shadow_reg;
  reg [7:0] array_config_live_reg;
  reg [7:0] divh_reg;
  reg [7:0] divl_reg;
  reg pgm_reg;
  reg lat_reg;
  reg auto_reg;
  reg [1:0] mode_reg;
  reg refsel_reg;
  reg valid_reg;
  reg [1:0] tgt_reg;
  reg [8:0] laddr_reg;
  reg [7:0] ldata_reg;
  reg [3:0] state_reg;
  reg [15:0] cnt_reg;
  reg done_reg;
  reg abort_reg;
  reg ld_pending_reg;
  reg osc_s1_reg;
  reg osc_s2_reg;
  reg osc_s3_reg;
  wire tick;

  wire secd = divh_reg[`EECTB_DIVH_SECD];

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock and timebase
  always @(posedge aclk) begin
    osc_s1_reg <= oscillator_output_clock;
    osc_s2_reg <= osc_s1_reg;
    osc_s3_reg <= osc_s2_reg;
  end

  eectb_divider #(
    .DW(11)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_sel(refsel_reg),
    .osc_edge(osc_s2_reg & ~osc_s3_reg),
    .divisor({divh_reg[2:0], divl_reg}),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshake, one write and one read at a time
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  wire wr_en = s_axi_awready;
  wire [7:0] wr_ofs = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0] wd = s_axi_wdata[7:0];
  assign s_axi_arready = ~s_axi_rvalid;

  // Only the low byte strobe is checked, though array write data and address also use bytes 1 and 2
  wire lane0 = s_axi_wstrb[0];
  wire mapped_w = (wr_ofs <= `EECTB_OFS_ARRW);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EECTB_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped_w ? `EECTB_RESP_OKAY : `EECTB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  wire [7:0] rd_ofs = {s_axi_araddr[7:2], 2'b00};
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (rd_ofs)
      `EECTB_OFS_CTRL: rd_mux[5:0] = {refsel_reg, mode_reg, auto_reg, lat_reg, pgm_reg};
      `EECTB_OFS_ACFG: rd_mux[7:0] = array_config_live_reg;
      `EECTB_OFS_DIVH: rd_mux[7:0] = divh_reg;
      `EECTB_OFS_DIVL: rd_mux[7:0] = divl_reg;
      `EECTB_OFS_NCFG: rd_mux[7:0] = cfg_shadow_reg;
      `EECTB_OFS_NDVH: rd_mux[7:0] = dvh_shadow_reg;
      `EECTB_OFS_NDVL: rd_mux[7:0] = dvl_shadow_reg;
      `EECTB_OFS_STAT: rd_mux[4:0] = {valid_reg, done_reg, abort_reg,
                                      state_reg[2], ~state_reg[0]};
      `EECTB_OFS_ARRW: rd_mux[23:0] = {ldata_reg, 7'h00, laddr_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EECTB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (rd_ofs <= `EECTB_OFS_ARRW) ? `EECTB_RESP_OKAY : `EECTB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch-and-program target check
  wire to_cfg = (wr_ofs == `EECTB_OFS_NCFG);
  wire to_dvh = (wr_ofs == `EECTB_OFS_NDVH);
  wire to_dvl = (wr_ofs == `EECTB_OFS_NDVL);
  wire to_arr = (wr_ofs == `EECTB_OFS_ARRW);
  wire [8:0] wr_arr_addr = s_axi_wdata[`EECTB_ARR_ADDR_HI:0];
  wire blk_prot = array_config_live_reg[wr_arr_addr[8:7]];
  // Divisor shadows refuse a latch once security is on
  wire wr_latchable = wr_en && lane0 && lat_reg && !pgm_reg &&
                        (to_cfg || (to_arr && !blk_prot) ||
                         ((to_dvh || to_dvl) && secd));

  ////////////////////////////////////////////////////////////////////////////
  // Sequence completion and commit value
  wire seq_end = state_reg[1] && tick && (cnt_reg == SEQ_TICKS - 16'h0001);
  wire [7:0] tgt_now = (tgt_reg == TGT_CFG) ? cfg_shadow_reg :
                       (tgt_reg == TGT_DVH) ? dvh_shadow_reg : dvl_shadow_reg;
  // Program only clears bits, any erase mode restores ones
  wire [7:0] nv_result = (mode_reg == 2'b00) ? (tgt_now & ldata_reg) : 8'hff;

  // Nonvolatile bytes survive system reset, only power-on sets them
  always @(posedge aclk) begin
    if (!por_n) begin
      cfg_shadow_reg <= `EECTB_NCFG_FACTORY;
      dvh_shadow_reg <= `EECTB_NDVH_FACTORY;
      dvl_shadow_reg <= `EECTB_NDVL_FACTORY;
    end else if (seq_end && !done_reg) begin
      case (tgt_reg)
        TGT_CFG: cfg_shadow_reg <= nv_result;
        TGT_DVH: dvh_shadow_reg <= nv_result;
        TGT_DVL: dvl_shadow_reg <= nv_result;
        default: cfg_shadow_reg <= cfg_shadow_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live copies, loaded from the shadows at every reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      array_config_live_reg <= 8'h00;
      divh_reg <= 8'h00;
      divl_reg <= 8'h00;
    end else if (ld_pending_reg) begin
      array_config_live_reg <= cfg_shadow_reg;
      divh_reg <= dvh_shadow_reg & `EECTB_DIVH_MASK;
      divl_reg <= dvl_shadow_reg;
    end else if (wr_en && lane0 && !lat_reg && secd) begin
      if (wr_ofs == `EECTB_OFS_DIVH) begin
        divh_reg <= wd & `EECTB_DIVH_MASK;
      end
      if (wr_ofs == `EECTB_OFS_DIVL) begin
        divl_reg <= wd;
      end
    end
  end

  // Load happens on the first edge after reset release
  always @(posedge aclk) begin
    ld_pending_reg <= !aresetn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and latch
  wire ctl_wr = wr_en && lane0 && (wr_ofs == `EECTB_OFS_CTRL);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pgm_reg <= 1'b0;
      lat_reg <= 1'b0;
      auto_reg <= 1'b0;
      mode_reg <= 2'b00;
      refsel_reg <= 1'b0;
      valid_reg <= 1'b0;
      tgt_reg <= TGT_CFG;
      laddr_reg <= 9'h000;
      ldata_reg <= 8'h00;
    end else begin
      if (seq_end && auto_reg) begin
        pgm_reg <= 1'b0;
      end
      if (ctl_wr) begin
        auto_reg <= wd[`EECTB_CTL_AUTO];
        mode_reg <= wd[`EECTB_CTL_MODE_HI:`EECTB_CTL_MODE_LO];
        refsel_reg <= wd[`EECTB_CTL_REFSEL];
        // Set needs latch and a valid latched write
        pgm_reg <= wd[`EECTB_CTL_PGM] & lat_reg & valid_reg;
        // Clearing both at once clears only program-enable
        if (wd[`EECTB_CTL_LAT] || !pgm_reg) begin
          lat_reg <= wd[`EECTB_CTL_LAT];
          if (!wd[`EECTB_CTL_LAT]) begin
            valid_reg <= 1'b0;
          end
        end
      end else if (wr_latchable) begin
        // Last valid write wins
        valid_reg <= 1'b1;
        tgt_reg <= to_cfg ? TGT_CFG : to_dvh ? TGT_DVH : to_dvl ? TGT_DVL : TGT_ARR;
        laddr_reg <= to_arr ? wr_arr_addr : 9'h000;
        ldata_reg <= to_arr ? s_axi_wdata[`EECTB_ARR_DATA_LO+7:`EECTB_ARR_DATA_LO] : wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program/erase sequencer
  // Wait mode is not an input: the sequence keeps running through it
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      done_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      // Status write of one clears the abort flag, a new abort wins
      if (wr_en && lane0 && (wr_ofs == `EECTB_OFS_STAT) && wd[2]) begin
        abort_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (pgm_reg && lat_reg && valid_reg && !stop_mode) begin
            state_reg <= ST_RUN;
            cnt_reg <= 16'h0000;
            done_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          if (stop_mode && pgm_reg) begin
            state_reg <= ST_SUSP;
          end else if (!pgm_reg) begin
            state_reg <= ST_FALL;
            cnt_reg <= 16'h0000;
          end else if (tick && !done_reg) begin
            done_reg <= seq_end;
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_SUSP: begin
          // Restart from the beginning once stop is left
          if (!stop_mode) begin
            state_reg <= ST_RUN;
            cnt_reg <= 16'h0000;
            done_reg <= 1'b0;
          end
        end
        ST_FALL: begin
          if (stop_mode) begin
            state_reg <= ST_IDLE;
            abort_reg <= 1'b1;
          end else if (tick) begin
            if (cnt_reg >= FALL_TICKS - 16'h0001) begin
              state_reg <= ST_IDLE;
            end
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // High voltage off while suspended
  assign program_voltage_on = state_reg[1] & pgm_reg & lat_reg & valid_reg & ~done_reg;
  assign array_access_ok = ~(state_reg[1] | state_reg[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Array commit to the cells outside
  always @(posedge aclk) begin
    if (!aresetn) begin
      array_commit <= 1'b0;
      array_addr <= 9'h000;
      array_data <= 8'h00;
      array_mode <= 2'b00;
    end else begin
      array_commit <= seq_end && !done_reg && (tgt_reg == TGT_ARR);
      array_addr <= laddr_reg;
      array_data <= ldata_reg;
      array_mode <= mode_reg;
    end
  end
endmodule // eectb_top
`default_nettype wire
